// ### hw/dtec_pkg.sv
`default_nettype none
package dtec_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_CNT0_DATA = 6'h0D;
	localparam logic [5:0] IDX_CNT0_CTRL = 6'h0E;
	localparam logic [5:0] IDX_CNT1_DATA = 6'h10;
	localparam logic [5:0] IDX_CNT1_CTRL = 6'h11;
	localparam logic [5:0] IDX_IRQ_CTRL = 6'h20;
	localparam logic [5:0] IDX_PORT_A = 6'h21;
	// control register field positions
	localparam int CTRL_EDGE_POS = 3;
	localparam int CTRL_RUN_POS = 4;
	localparam int CTRL_SRC_POS = 5;
	localparam int CTRL_MODE_POS = 6;
	// interrupt control and port A field positions
	localparam int IRQ_EN_POS = 0;
	localparam int IRQ_FLAG_POS = 2;
	localparam int PORT_A3_POS = 0;
	// operating modes
	localparam logic [1:0] MODE_EVENT = 2'h1;
	localparam logic [1:0] MODE_TIMER = 2'h2;
	localparam logic [1:0] MODE_PULSE = 2'h3;
	// reset values and limits
	localparam logic RST_EDGE = 1'h1;
	localparam logic RST_PORT_A3 = 1'h1;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [1:0] PRESCALE_LAST = 2'h3;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} dtec_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} dtec_apb_rsp_type;

	typedef struct packed {
		logic active_edge_select;
		logic count_run_enable;
		logic clock_source_select;
		logic [1:0] op_mode;
		logic pulse_measuring;
		logic pin_prev;
		logic [7:0] preload;
		logic [7:0] count;
	} dtec_chan_type;

	typedef struct packed {
		dtec_apb_rsp_type rsp;
		dtec_chan_type [1:0] chan;
		logic [1:0] prescale;
		logic [1:0] irq_enable;
		logic [1:0] irq_flag;
		logic port_a_bit3;
		logic divider_toggle;
		logic divided_frequency_output;
		logic irq;
		logic wake;
	} dtec_state_type;
endpackage
`default_nettype wire

// ### hw/dtec_top.sv
// Overview of operation
// RL1 - edge bit: 0 rising, 1 falling
// RL2 - run bit 4 gates counting
// RL3 - counter0 bit5: rtc tick or system clock
// RL4 - counter1 bit5: option tick or clock/4
// RL5 - bits 7:6 pick event, timer, pulse mode
// RL6 - pulse mode overflow reloads and flags too
// RL7 - pulse mode clears run after one measurement
// RL8 - other modes never clear run themselves
// RL9 - any overflow wakes the part
// RL10 - one counter only feeds the divider pad
// RL11 - cleared enable blocks interrupt in every mode
// RL12 - port latch 0 enables pad, 1 holds low
// RL13 - stopped: preload write also loads counter
// RL14 - running: preload write waits for overflow
// RL15 - counter read blocks counter clock
// RL16 - software loads start value before run
// RL17 - software toggles run once before use
// RL18 - pad toggles each overflow
// RL19 - stopped pad: latch 1 drives low
// RL20 - software sets pad push-pull first
// RL21 - count to FFH, reload, set flag
// RL22 - pulse mode counts until pin returns
// RL23 - data write preloads, read gives count
// RL24 - counter0 clock divide fixed at build
// RL25 - event mode counts selected pin edges
// RL26 - control bits 2:0 read zero
//
// Implementation choices: the address map and the APB slave port.
`default_nettype none
module dtec_top #(
	parameter bit SYS_DIV4_0 = 1'b1,
	parameter bit DIV_SRC_SEL = 1'b0
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// register bus
	input wire dtec_pkg::dtec_apb_req_type apb_req_i,
	output var dtec_pkg::dtec_apb_rsp_type apb_rsp_o,
	// clock sources and count pins
	input wire logic rtc_tick_i,
	input wire logic option_tick_i,
	input wire logic [1:0] timer_pin_i,
	// events and pad
	output logic irq_o,
	output logic wake_o,
	output logic divided_frequency_output_o
);
	import dtec_pkg::*;

	dtec_state_type r;
	dtec_state_type next_r;
	logic access;
	logic wr;
	logic [5:0] idx;
	logic prescale_tick;
	logic [1:0] itick;
	logic [1:0] act;
	logic [1:0] tick;
	logic [1:0] ovf;
	logic [1:0] blocked;
	logic [1:0] data_wr;
	logic [1:0] ctrl_wr;

	always_comb begin
		next_r = r;
		idx = apb_req_i.paddr[7:2];
		access = apb_req_i.psel & apb_req_i.penable;
		wr = access & r.rsp.pready & apb_req_i.pwrite;
		itick = 2'h0;
		act = 2'h0;
		tick = 2'h0;
		ovf = 2'h0;
		blocked = 2'h0;
		data_wr = 2'h0;
		ctrl_wr = 2'h0;
		// bus slave: one wait cycle, then pready for one cycle
		next_r.rsp.pready = access & ~r.rsp.pready;
		next_r.rsp.pslverr = 1'b0;
		if (access & ~r.rsp.pready) begin
			next_r.rsp.prdata = 32'h0;
			case (idx)
				IDX_CNT0_DATA, IDX_CNT1_DATA: begin
					next_r.rsp.prdata[7:0] = r.chan[idx == IDX_CNT1_DATA].count; // RL23
				end
				IDX_CNT0_CTRL, IDX_CNT1_CTRL: begin
					next_r.rsp.prdata[7:0] = {r.chan[idx == IDX_CNT1_CTRL].op_mode,
						r.chan[idx == IDX_CNT1_CTRL].clock_source_select,
						r.chan[idx == IDX_CNT1_CTRL].count_run_enable,
						r.chan[idx == IDX_CNT1_CTRL].active_edge_select,
						3'h0}; // RL26
				end
				IDX_IRQ_CTRL: begin
					next_r.rsp.prdata[3:0] = {r.irq_flag, r.irq_enable};
				end
				IDX_PORT_A: begin
					next_r.rsp.prdata[PORT_A3_POS] = r.port_a_bit3;
				end
				default: begin
					next_r.rsp.pslverr = 1'b1;
				end
			endcase
		end
		// shared divide-by-four prescaler
		next_r.prescale = 2'(r.prescale + 2'h1);
		prescale_tick = r.prescale == PRESCALE_LAST;
		itick[0] = r.chan[0].clock_source_select ?
			(SYS_DIV4_0 ? prescale_tick : 1'b1) : rtc_tick_i; // RL3 RL24
		itick[1] = r.chan[1].clock_source_select ?
			prescale_tick : option_tick_i; // RL4
		for (int i = 0; i < 2; i++) begin
			data_wr[i] = wr & (idx == (i == 0 ? IDX_CNT0_DATA : IDX_CNT1_DATA));
			ctrl_wr[i] = wr & (idx == (i == 0 ? IDX_CNT0_CTRL : IDX_CNT1_CTRL));
			blocked[i] = apb_req_i.psel & ~apb_req_i.pwrite &
				(idx == (i == 0 ? IDX_CNT0_DATA : IDX_CNT1_DATA)); // RL15
			next_r.chan[i].pin_prev = timer_pin_i[i];
			act[i] = (timer_pin_i[i] != r.chan[i].pin_prev) &
				(timer_pin_i[i] != r.chan[i].active_edge_select); // RL1
			case (r.chan[i].op_mode) // RL5
				MODE_EVENT: tick[i] = act[i]; // RL25
				MODE_TIMER: tick[i] = itick[i];
				MODE_PULSE: tick[i] = r.chan[i].pulse_measuring & itick[i]; // RL22
				default: tick[i] = 1'b0;
			endcase
			tick[i] = tick[i] & r.chan[i].count_run_enable & ~blocked[i]; // RL2
			if (tick[i]) begin
				ovf[i] = r.chan[i].count == CNT_MAX;
				next_r.chan[i].count = ovf[i] ? r.chan[i].preload :
					8'(r.chan[i].count + 8'h01); // RL21 RL6
			end
			if (r.chan[i].op_mode == MODE_PULSE && r.chan[i].count_run_enable) begin
				if (!r.chan[i].pulse_measuring && act[i]) begin
					next_r.chan[i].pulse_measuring = 1'b1; // RL22
				end
				if (r.chan[i].pulse_measuring &&
						timer_pin_i[i] == r.chan[i].active_edge_select) begin
					next_r.chan[i].pulse_measuring = 1'b0;
					next_r.chan[i].count_run_enable = 1'b0; // RL7
				end
			end
			if (ctrl_wr[i]) begin
				next_r.chan[i].active_edge_select = apb_req_i.pwdata[CTRL_EDGE_POS];
				next_r.chan[i].count_run_enable = apb_req_i.pwdata[CTRL_RUN_POS]; // RL8
				next_r.chan[i].clock_source_select = apb_req_i.pwdata[CTRL_SRC_POS];
				next_r.chan[i].op_mode = apb_req_i.pwdata[CTRL_MODE_POS +: 2];
				next_r.chan[i].pulse_measuring = 1'b0;
			end
			if (data_wr[i]) begin
				next_r.chan[i].preload = apb_req_i.pwdata[7:0]; // RL14 RL23
				if (!r.chan[i].count_run_enable) begin
					next_r.chan[i].count = apb_req_i.pwdata[7:0]; // RL13
				end
			end
		end
		// flags: hardware set wins over software write
		if (wr && idx == IDX_IRQ_CTRL) begin
			next_r.irq_enable = apb_req_i.pwdata[IRQ_EN_POS +: 2];
			next_r.irq_flag = apb_req_i.pwdata[IRQ_FLAG_POS +: 2];
		end
		next_r.irq_flag = next_r.irq_flag | ovf; // RL21
		if (wr && idx == IDX_PORT_A) begin
			next_r.port_a_bit3 = apb_req_i.pwdata[PORT_A3_POS];
		end
		next_r.irq = |(next_r.irq_flag & next_r.irq_enable); // RL11
		next_r.wake = |ovf; // RL9
		if (ovf[DIV_SRC_SEL]) begin
			next_r.divider_toggle = ~r.divider_toggle; // RL10 RL18
		end
		next_r.divided_frequency_output =
			~r.port_a_bit3 & r.divider_toggle; // RL12 RL19
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			r <= '0;
			r.chan[0].active_edge_select <= RST_EDGE;
			r.chan[1].active_edge_select <= RST_EDGE;
			r.port_a_bit3 <= RST_PORT_A3;
		end else begin
			r <= next_r;
		end
	end

	assign apb_rsp_o = r.rsp;
	assign irq_o = r.irq;
	assign wake_o = r.wake;
	assign divided_frequency_output_o = r.divided_frequency_output;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);

	unused_bits_a: assert property ( // RL26
		access & ~r.rsp.pready & ~apb_req_i.pwrite & (idx == IDX_CNT0_CTRL)
		|=> apb_rsp_o.prdata[2:0] == 3'h0)
		else $error("control low bits not zero");
	stop_hold_a: assert property ( // RL2
		!r.chan[0].count_run_enable & !data_wr[0] |=> $stable(r.chan[0].count))
		else $error("stopped counter moved");
	ovf_reload_a: assert property ( // RL21
		tick[0] & (r.chan[0].count == CNT_MAX) & !data_wr[0]
		|=> (r.chan[0].count == $past(r.chan[0].preload)) & r.irq_flag[0])
		else $error("overflow did not reload and flag");
	pulse_clear_a: assert property ( // RL7
		(r.chan[1].op_mode == MODE_PULSE) & r.chan[1].count_run_enable &
		r.chan[1].pulse_measuring &
		(timer_pin_i[1] == r.chan[1].active_edge_select) & !ctrl_wr[1]
		|=> !r.chan[1].count_run_enable)
		else $error("pulse mode run bit not cleared");
	run_keep_a: assert property ( // RL8
		(r.chan[0].op_mode != MODE_PULSE) & r.chan[0].count_run_enable &
		!ctrl_wr[0] |=> r.chan[0].count_run_enable)
		else $error("run bit cleared by itself");
	preload_stop_a: assert property ( // RL13
		data_wr[1] & !r.chan[1].count_run_enable
		|=> r.chan[1].count == $past(apb_req_i.pwdata[7:0]))
		else $error("stopped preload write missed counter");
	preload_run_a: assert property ( // RL14
		data_wr[0] & r.chan[0].count_run_enable & !tick[0]
		|=> $stable(r.chan[0].count))
		else $error("running counter disturbed by write");
	read_block_a: assert property ( // RL15
		blocked[0] |=> $stable(r.chan[0].count))
		else $error("counter ticked during read");
	pad_low_a: assert property ( // RL12
		r.port_a_bit3 |=> !divided_frequency_output_o)
		else $error("divider pad not held low");
	irq_gate_a: assert property ( // RL11
		(r.irq_enable == 2'h0) & !wr |=> !irq_o)
		else $error("masked interrupt raised");
	wake_pulse_a: assert property ( // RL9
		|ovf |=> wake_o)
		else $error("overflow did not wake");
	event_edge_a: assert property ( // RL25
		(r.chan[1].op_mode == MODE_EVENT) & r.chan[1].count_run_enable &
		!blocked[1] & act[1] & (r.chan[1].count != CNT_MAX)
		|=> r.chan[1].count == 8'($past(r.chan[1].count) + 8'h01))
		else $error("event edge not counted");
	pad_toggle_a: assert property ( // RL18
		ovf[DIV_SRC_SEL] & !r.port_a_bit3 & !wr
		|=> ##1 divided_frequency_output_o != $past(divided_frequency_output_o))
		else $error("pad did not toggle on overflow");

	ovf_seen_c: cover property (ovf[0] ##1 wake_o);
	pulse_done_c: cover property (r.chan[1].pulse_measuring
		##1 !r.chan[1].count_run_enable);
	pad_toggle_c: cover property (!divided_frequency_output_o
		##[1:600] divided_frequency_output_o);
	irq_seen_c: cover property (irq_o);
endmodule // dtec_top
`default_nettype wire

// ### sim/dtec_pin_model.sv
`default_nettype none
module dtec_pin_model (
	// clock
	input wire logic mclk_i,
	// external count pin
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin_o = 1'b0;
	// drive a level, then hold it w cycles
	task automatic level(input logic v, input int w);
		@(posedge mclk_i);
		pin_o <= v;
		repeat (w) @(posedge mclk_i);
	endtask
	// n high pulses, each w+1 cycles high and w+1 low
	task automatic pulses(input logic [7:0] n, input int w);
		repeat (n) begin
			level(1'b1, w);
			level(1'b0, w);
		end
	endtask
endmodule // dtec_pin_model
`default_nettype wire

// ### sim/dual_timer_event_counter_pfd_bench.sv
`default_nettype none
module dual_timer_event_counter_pfd_bench import dtec_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 0, rstn_i = 0, rtc = 0, opt = 0, pin0 = 0;
	logic irq, wake, pad, e;
	wire pin1;
	dtec_apb_req_type req = '0;
	dtec_apb_rsp_type rsp;
	logic [31:0] q;
	logic [7:0] pv, k;
	int err_total = 0, comparisons = 0, cyc = 0, wakes = 0, n;

	dtec_top #(.SYS_DIV4_0(1'b1), .DIV_SRC_SEL(1'b0)) dtec_top_i (
		.mclk_i(mclk_i), .rstn_i(rstn_i),
		.apb_req_i(req), .apb_rsp_o(rsp),
		.rtc_tick_i(rtc), .option_tick_i(opt),
		.timer_pin_i({pin1, pin0}), .irq_o(irq), .wake_o(wake),
		.divided_frequency_output_o(pad));
	dtec_pin_model pin_model_i (.mclk_i(mclk_i), .pin_o(pin1));

	initial forever #10 mclk_i = ~mclk_i;
	// unused tick sources and pin get random levels
	always @(posedge mclk_i) begin
		rtc <= 1'($urandom);
		opt <= 1'($urandom);
		pin0 <= 1'($urandom);
		cyc <= cyc + 1;
		if (wake === 1'b1) wakes <= wakes + 1;
		if (cyc == 30000) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk_i);
		req <= '{1'b1, 1'b0, w, {a, 2'h0}, d};
		@(posedge mclk_i);
		req.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge mclk_i);
			i++;
		end while (rsp.pready !== 1'b1 && i < 20);
		q = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// cycles until the pad changes level
	task automatic wait_pad();
		logic p;
		p = pad;
		n = 0;
		while (pad === p && n < 3000) begin
			@(posedge mclk_i);
			n++;
		end
	endtask
	task end_of_test();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		void'($urandom(32'h5C972896));
		repeat (5) @(posedge mclk_i);
		rstn_i <= 1'b1;
		rd(IDX_CNT0_CTRL, 32'h08);
		rd(IDX_PORT_A, 32'h01);
		apb(1'b0, 6'h3F, 32'h0);
		chk(e, 1'b1);
		chk(q, 32'h0);
		wr(IDX_CNT0_CTRL, 32'h0F);
		rd(IDX_CNT0_CTRL, 32'h08);
		wr(IDX_CNT0_CTRL, 32'h10);
		wr(IDX_CNT0_CTRL, 32'h00);
		pv = 8'hE0 + 8'($urandom % 30);
		wr(IDX_CNT0_DATA, {24'h0, pv});
		rd(IDX_CNT0_DATA, {24'h0, pv});
		wr(IDX_PORT_A, 32'h0);
		wr(IDX_CNT0_CTRL, 32'hB0);
		wait_pad();
		wait_pad();
		wait_pad();
		chk(n, 4 * (256 - pv));
		chk(wakes > 0, 1'b1);
		chk(irq, 1'b0);
		rd(IDX_IRQ_CTRL, 32'h04);
		rd(IDX_CNT0_CTRL, 32'hB0);
		wr(IDX_IRQ_CTRL, 32'h01);
		wait_pad();
		repeat (2) @(posedge mclk_i);
		chk(irq, 1'b1);
		wr(IDX_PORT_A, 32'h1);
		repeat (4) @(posedge mclk_i);
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk_i);
			chk(pad, 1'b0);
		end
		wr(IDX_CNT0_CTRL, 32'h00);
		wr(IDX_IRQ_CTRL, 32'h00);
		pv = 8'($urandom % 200);
		wr(IDX_CNT1_DATA, {24'h0, pv});
		rd(IDX_CNT1_DATA, {24'h0, pv});
		k = 8'(1 + $urandom % 9);
		wr(IDX_CNT1_CTRL, 32'h50);
		pin_model_i.pulses(k, 3);
		rd(IDX_CNT1_DATA, {24'h0, pv + k});
		wr(IDX_CNT1_CTRL, 32'h58);
		pin_model_i.level(1'b1, 3);
		rd(IDX_CNT1_DATA, {24'h0, pv + k});
		pin_model_i.level(1'b0, 3);
		rd(IDX_CNT1_DATA, {24'h0, pv + k + 8'h1});
		wr(IDX_CNT1_CTRL, 32'hF0);
		pin_model_i.pulses(1, 40);
		rd(IDX_CNT1_CTRL, 32'hE0);
		end_of_test();
	end
endmodule // dual_timer_event_counter_pfd_bench
`default_nettype wire
